/* File: hdl/iicc_ctrl.sv */
// interrupt inching executor with coordinate frame selection and wishbone slave
`timescale 1ns/1ps
`default_nettype none
module iicc_ctrl (
   input  wire logic        ref_clk,    // 25 MHz clock
   input  wire logic        rstn,       // synchronous reset, active low
   input  wire logic        wbCyc,      // wishbone cycle
   input  wire logic        wbStb,      // wishbone strobe
   input  wire logic        wbWe,       // wishbone write enable
   input  wire logic [3:0]  wbSel,      // wishbone byte selects
   input  wire logic [7:0]  wbAdr,      // wishbone byte address
   input  wire logic [31:0] wbDatI,     // wishbone write data
   output logic      [31:0] wbDatO,     // wishbone read data
   output logic             wbAck,      // wishbone acknowledge
   input  wire logic        genIn1,     // general input 1, asynchronous
   input  wire logic        genIn2,     // general input 2, asynchronous
   output logic             stepX,      // x axis step pulse
   output logic             stepY,      // y axis step pulse
   output logic             dirOut,     // motion direction, 1 negative
   output logic      [31:0] speedCmd,   // commanded speed to drive
   output logic      [15:0] rampTime,   // scaled ramp time to drive
   output logic             irq         // level interrupt
);
   iicc_pkg::iicc_wbreq_t req;
   iicc_pkg::iicc_state_t state_r;
   iicc_pkg::iicc_stat_t  stat;
   logic [31:0] ctrl_r, dist_r, spd1_r, spd2_r, vmax_r, ovr_r, ramp_r, slim_r;
   logic [31:0] ofs_r, pofs_r, wofs_r, posX_r, posY_r, remain_r, accum_r, senseCnt_r;
   logic [iicc_pkg::IRQ_W-1:0] irqSt_r, irqEn_r, irqSet, irqClr;
   logic [2:0]  s1_r, s2_r;
   logic        in1Lvl_r, in2Lvl_r, axis_r, use2_r, frameWrk_r, stopMode_r;
   logic        acc, wr, cmdStrb, edgeHit, stepPulse;
   logic [3:0]  cmd;
   logic [31:0] spdEff, rate;
   logic [63:0] rampProd;

   assign req = '{cyc: wbCyc, stb: wbStb, we: wbWe, sel: wbSel, adr: wbAdr, dat: wbDatI};
   assign acc = req.cyc & req.stb & ~wbAck;
   assign wr = acc & req.we & (req.sel == 4'hf);
   assign cmdStrb = wr & (req.adr == iicc_pkg::ADR_CTRL);
   assign cmd = req.dat[3:0];
   assign stat = '{busy: (state_r != iicc_pkg::ST_IDLE), frameWrk: frameWrk_r, stopMode: stopMode_r,
                   state: state_r};

   // input conditioning: a change counts once stage 2 and 3 agree
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         s1_r <= 3'h0;
         s2_r <= 3'h0;
      end else begin
         s1_r <= {s1_r[1:0], genIn1};
         s2_r <= {s2_r[1:0], genIn2};
      end
   end
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         in1Lvl_r <= 1'b0;
         in2Lvl_r <= 1'b0;
      end else begin
         if (s1_r[1] == s1_r[2]) begin
            in1Lvl_r <= s1_r[2];
         end
         if (s2_r[1] == s2_r[2]) begin
            in2Lvl_r <= s2_r[2];
         end
      end
   end
   // rising edge of the chosen axis input
   assign edgeHit = axis_r ? (s2_r[1] & s2_r[2] & ~in2Lvl_r) : (s1_r[1] & s1_r[2] & ~in1Lvl_r);

   // speed selection: clamp to maximum ignores override, else apply override
   always_comb begin
      spdEff = (use2_r && (state_r == iicc_pkg::ST_POS)) ? spd2_r : spd1_r;
      if (spdEff > vmax_r) begin
         rate = vmax_r;
      end else begin
         rate = 32'((64'(spdEff) * 64'(ovr_r)) / 64'(iicc_pkg::OVR_FULL));
      end
      rampProd = (vmax_r == iicc_pkg::RESET_ZERO) ? 64'h0 : (64'(ramp_r) * 64'(rate)) / 64'(vmax_r);
   end

   // rate accumulator produces step pulses at rate steps per second
   assign stepPulse = (accum_r + rate) >= 32'(iicc_pkg::CLK_HZ);
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         accum_r <= iicc_pkg::RESET_ZERO;
      end else if (state_r == iicc_pkg::ST_IDLE || state_r == iicc_pkg::ST_DONE) begin
         accum_r <= iicc_pkg::RESET_ZERO;
      end else if (stepPulse) begin
         accum_r <= accum_r + rate - 32'(iicc_pkg::CLK_HZ);
      end else begin
         accum_r <= accum_r + rate;
      end
   end

   // inching sequencer
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         state_r    <= iicc_pkg::ST_IDLE;
         axis_r     <= 1'b0;
         use2_r     <= 1'b0;
         remain_r   <= iicc_pkg::RESET_ZERO;
         senseCnt_r <= iicc_pkg::RESET_ZERO;
      end else begin
         unique case (state_r)
            iicc_pkg::ST_IDLE: begin
               if (cmdStrb && cmd == iicc_pkg::CMD_INCH &&
                   !(req.dat[iicc_pkg::CTL_USE2] && spd2_r >= spd1_r)) begin
                  state_r <= iicc_pkg::ST_FEED;
                  axis_r  <= req.dat[iicc_pkg::CTL_AXIS];
                  use2_r  <= req.dat[iicc_pkg::CTL_USE2];
               end
            end
            iicc_pkg::ST_FEED: begin
               if (cmdStrb && cmd == iicc_pkg::CMD_STOP) begin
                  state_r <= iicc_pkg::ST_DONE;
               end else if (edgeHit) begin
                  state_r    <= iicc_pkg::ST_SENSE;
                  senseCnt_r <= iicc_pkg::RESET_ZERO;
               end
            end
            iicc_pkg::ST_SENSE: begin
               // edge already seen; go at once, well inside the sensing window
               if (senseCnt_r < 32'(iicc_pkg::SENSE_CYC)) begin
                  state_r  <= iicc_pkg::ST_POS;
                  remain_r <= dist_r;
               end
               senseCnt_r <= senseCnt_r + 32'h1;
            end
            iicc_pkg::ST_POS: begin
               if ((cmdStrb && cmd == iicc_pkg::CMD_STOP) || remain_r == iicc_pkg::RESET_ZERO) begin
                  state_r <= iicc_pkg::ST_DONE;
               end else if (stepPulse) begin
                  remain_r <= remain_r - 32'h1;
               end
            end
            iicc_pkg::ST_DONE: begin
               state_r <= iicc_pkg::ST_IDLE;
            end
            default: begin
               state_r <= iicc_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // positions: soft limit with defined origin, zeroing otherwise
   logic orgDef, moving, stepOk, limHit;
   logic [31:0] posSel;
   assign orgDef = axis_r ? ctrl_r[iicc_pkg::CTL_ORGY] : ctrl_r[iicc_pkg::CTL_ORGX];
   assign moving = (state_r == iicc_pkg::ST_FEED) || (state_r == iicc_pkg::ST_POS);
   // no step once the distance is used up, even if the accumulator wraps in that cycle
   assign stepOk = (state_r == iicc_pkg::ST_FEED) ||
                   (state_r == iicc_pkg::ST_POS && remain_r != iicc_pkg::RESET_ZERO);
   assign posSel = axis_r ? posY_r : posX_r;
   assign limHit = orgDef && stepOk && stepPulse &&
                   ($signed(posSel) >= $signed(slim_r) || $signed(posSel) <= -$signed(slim_r));
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         posX_r <= iicc_pkg::RESET_ZERO;
         posY_r <= iicc_pkg::RESET_ZERO;
      end else if (!orgDef && ((state_r == iicc_pkg::ST_IDLE && cmdStrb && cmd == iicc_pkg::CMD_INCH) ||
                               (state_r == iicc_pkg::ST_FEED && edgeHit))) begin
         if (axis_r == 1'b0 && !(state_r == iicc_pkg::ST_IDLE && req.dat[iicc_pkg::CTL_AXIS])) begin
            posX_r <= iicc_pkg::RESET_ZERO;
         end else begin
            posY_r <= iicc_pkg::RESET_ZERO;
         end
      end else if (stepOk && stepPulse && !limHit) begin
         if (axis_r) begin
            posY_r <= ctrl_r[iicc_pkg::CTL_DIR] ? posY_r - 32'h1 : posY_r + 32'h1;
         end else begin
            posX_r <= ctrl_r[iicc_pkg::CTL_DIR] ? posX_r - 32'h1 : posX_r + 32'h1;
         end
      end
   end

   // coordinate frame and working offset
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         frameWrk_r <= 1'b0;
         wofs_r     <= iicc_pkg::RESET_ZERO;
         stopMode_r <= 1'b0;
      end else if (cmdStrb) begin
         unique case (cmd)
            iicc_pkg::CMD_REFSEL, iicc_pkg::CMD_REFRET, iicc_pkg::CMD_OSRCH: frameWrk_r <= 1'b0;
            iicc_pkg::CMD_WRKSEL, iicc_pkg::CMD_WRKRET: frameWrk_r <= 1'b1;
            iicc_pkg::CMD_PSTART: wofs_r <= pofs_r;
            iicc_pkg::CMD_SETOFS: begin
               if (!($signed(ofs_r) > $signed(slim_r) || $signed(ofs_r) < -$signed(slim_r))) begin
                  wofs_r <= ofs_r;
               end
            end
            iicc_pkg::CMD_INTERP: stopMode_r <= 1'b0;
            iicc_pkg::CMD_INCH: stopMode_r <= 1'b1;
            default: begin
            end
         endcase
      end
   end

   // register writes
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         ctrl_r <= iicc_pkg::RESET_ZERO;
         dist_r <= iicc_pkg::RESET_ZERO;
         spd1_r <= iicc_pkg::RESET_ZERO;
         spd2_r <= iicc_pkg::RESET_ZERO;
         vmax_r <= iicc_pkg::RESET_ZERO;
         ovr_r  <= iicc_pkg::OVR_FULL;
         ramp_r <= iicc_pkg::RESET_ZERO;
         slim_r <= iicc_pkg::RESET_ZERO;
         ofs_r  <= iicc_pkg::RESET_ZERO;
         pofs_r <= iicc_pkg::RESET_ZERO;
         irqEn_r <= '0;
      end else if (wr) begin
         unique case (req.adr)
            iicc_pkg::ADR_CTRL:  ctrl_r <= req.dat;
            iicc_pkg::ADR_DIST:  dist_r <= req.dat;
            iicc_pkg::ADR_SPD1:  spd1_r <= req.dat;
            iicc_pkg::ADR_SPD2:  spd2_r <= req.dat;
            iicc_pkg::ADR_VMAX:  vmax_r <= req.dat;
            iicc_pkg::ADR_OVR:   ovr_r  <= req.dat;
            iicc_pkg::ADR_RAMP:  ramp_r <= req.dat;
            iicc_pkg::ADR_SLIM:  slim_r <= req.dat;
            iicc_pkg::ADR_OFS:   ofs_r  <= req.dat;
            iicc_pkg::ADR_POFS:  pofs_r <= req.dat;
            iicc_pkg::ADR_IRQEN: irqEn_r <= req.dat[iicc_pkg::IRQ_W-1:0];
            default: begin
            end
         endcase
      end
   end

   // interrupt status: set wins over clear
   always_comb begin
      irqSet = '0;
      irqSet[iicc_pkg::IRQ_DONE]   = (state_r == iicc_pkg::ST_DONE);
      irqSet[iicc_pkg::IRQ_SPDERR] = cmdStrb && cmd == iicc_pkg::CMD_INCH && state_r == iicc_pkg::ST_IDLE &&
                                     req.dat[iicc_pkg::CTL_USE2] && spd2_r >= spd1_r;
      irqSet[iicc_pkg::IRQ_OFSERR] = cmdStrb && cmd == iicc_pkg::CMD_SETOFS &&
                                     ($signed(ofs_r) > $signed(slim_r) || $signed(ofs_r) < -$signed(slim_r));
      irqSet[iicc_pkg::IRQ_LIMERR] = limHit;
      irqSet[iicc_pkg::IRQ_TRIG]   = (state_r == iicc_pkg::ST_FEED) && edgeHit;
      irqClr = (wr && req.adr == iicc_pkg::ADR_IRQCLR) ? req.dat[iicc_pkg::IRQ_W-1:0] : '0;
   end
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         irqSt_r <= '0;
         irq     <= 1'b0;
      end else begin
         irqSt_r <= (irqSt_r & ~irqClr) | irqSet;
         irq     <= |(((irqSt_r & ~irqClr) | irqSet) & irqEn_r);
      end
   end

   // bus answer, one cycle after strobe
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         wbAck  <= 1'b0;
         wbDatO <= iicc_pkg::RESET_ZERO;
      end else begin
         wbAck <= acc;
         if (acc && !req.we) begin
            unique case (req.adr)
               iicc_pkg::ADR_CTRL:  wbDatO <= ctrl_r;
               iicc_pkg::ADR_STAT:  wbDatO <= {26'h0, stat};
               iicc_pkg::ADR_DIST:  wbDatO <= dist_r;
               iicc_pkg::ADR_SPD1:  wbDatO <= spd1_r;
               iicc_pkg::ADR_SPD2:  wbDatO <= spd2_r;
               iicc_pkg::ADR_VMAX:  wbDatO <= vmax_r;
               iicc_pkg::ADR_OVR:   wbDatO <= ovr_r;
               iicc_pkg::ADR_RAMP:  wbDatO <= ramp_r;
               iicc_pkg::ADR_POSX:  wbDatO <= posX_r;
               iicc_pkg::ADR_POSY:  wbDatO <= posY_r;
               iicc_pkg::ADR_SLIM:  wbDatO <= slim_r;
               iicc_pkg::ADR_OFS:   wbDatO <= ofs_r;
               iicc_pkg::ADR_POFS:  wbDatO <= pofs_r;
               iicc_pkg::ADR_IRQST: wbDatO <= {27'h0, irqSt_r};
               iicc_pkg::ADR_IRQEN: wbDatO <= {27'h0, irqEn_r};
               iicc_pkg::ADR_FRAME: wbDatO <= {31'h0, frameWrk_r};
               iicc_pkg::ADR_WOFS:  wbDatO <= wofs_r;
               default:             wbDatO <= iicc_pkg::RESET_ZERO;
            endcase
         end
      end
   end

   // drive outputs
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         stepX    <= 1'b0;
         stepY    <= 1'b0;
         dirOut   <= 1'b0;
         speedCmd <= iicc_pkg::RESET_ZERO;
         rampTime <= 16'h0;
      end else begin
         stepX    <= stepOk && stepPulse && !limHit && !axis_r;
         stepY    <= stepOk && stepPulse && !limHit && axis_r;
         dirOut   <= ctrl_r[iicc_pkg::CTL_DIR];
         speedCmd <= moving ? rate : iicc_pkg::RESET_ZERO;
         rampTime <= rampProd[15:0];
      end
   end
endmodule
`default_nettype wire

/* File: hdl/iicc_pkg.sv */
// package for the interrupt inching and coordinate frame controller
package iicc_pkg;
   localparam int unsigned CLK_HZ          = 25000000;
   localparam int unsigned SENSE_DELAY_US  = 1000;
   localparam int unsigned SENSE_CYC       = (CLK_HZ / 1000000) * SENSE_DELAY_US;
   localparam int unsigned TICK_HZ         = 1000;
   localparam int unsigned TICK_CYC        = CLK_HZ / TICK_HZ;
   localparam logic [7:0] ADR_CTRL   = 8'h00;
   localparam logic [7:0] ADR_STAT   = 8'h04;
   localparam logic [7:0] ADR_DIST   = 8'h08;
   localparam logic [7:0] ADR_SPD1   = 8'h0c;
   localparam logic [7:0] ADR_SPD2   = 8'h10;
   localparam logic [7:0] ADR_VMAX   = 8'h14;
   localparam logic [7:0] ADR_OVR    = 8'h18;
   localparam logic [7:0] ADR_RAMP   = 8'h1c;
   localparam logic [7:0] ADR_POSX   = 8'h20;
   localparam logic [7:0] ADR_POSY   = 8'h24;
   localparam logic [7:0] ADR_SLIM   = 8'h28;
   localparam logic [7:0] ADR_OFS    = 8'h2c;
   localparam logic [7:0] ADR_POFS   = 8'h30;
   localparam logic [7:0] ADR_IRQST  = 8'h34;
   localparam logic [7:0] ADR_IRQEN  = 8'h38;
   localparam logic [7:0] ADR_IRQCLR = 8'h3c;
   localparam logic [7:0] ADR_FRAME  = 8'h40;
   localparam logic [7:0] ADR_WOFS   = 8'h44;
   // command codes written to CTRL[3:0]
   localparam logic [3:0] CMD_INCH   = 4'h1;
   localparam logic [3:0] CMD_REFSEL = 4'h2;
   localparam logic [3:0] CMD_WRKSEL = 4'h3;
   localparam logic [3:0] CMD_SETOFS = 4'h4;
   localparam logic [3:0] CMD_REFRET = 4'h5;
   localparam logic [3:0] CMD_WRKRET = 4'h6;
   localparam logic [3:0] CMD_OSRCH  = 4'h7;
   localparam logic [3:0] CMD_STOP   = 4'h8;
   localparam logic [3:0] CMD_PSTART = 4'h9;
   localparam logic [3:0] CMD_INTERP = 4'ha;
   localparam int unsigned CTL_AXIS   = 4;
   localparam int unsigned CTL_USE2   = 5;
   localparam int unsigned CTL_DIR    = 6;
   localparam int unsigned CTL_ORGX   = 8;
   localparam int unsigned CTL_ORGY   = 9;
   localparam int unsigned CTL_PASS   = 10;
   localparam int unsigned IRQ_DONE   = 0;
   localparam int unsigned IRQ_SPDERR = 1;
   localparam int unsigned IRQ_OFSERR = 2;
   localparam int unsigned IRQ_LIMERR = 3;
   localparam int unsigned IRQ_TRIG   = 4;
   localparam int unsigned IRQ_W      = 5;
   localparam logic [31:0] OVR_FULL   = 32'h000003e8;
   localparam logic [31:0] RESET_ZERO = 32'h00000000;
   typedef enum logic [2:0] {
      ST_IDLE  = 3'b000,
      ST_FEED  = 3'b001,
      ST_SENSE = 3'b010,
      ST_POS   = 3'b011,
      ST_DONE  = 3'b100
   } iicc_state_t;
   typedef struct packed {
      logic        cyc;
      logic        stb;
      logic        we;
      logic [3:0]  sel;
      logic [7:0]  adr;
      logic [31:0] dat;
   } iicc_wbreq_t;
   typedef struct packed {
      logic        busy;
      logic        frameWrk;
      logic        stopMode;
      logic [2:0]  state;
   } iicc_stat_t;
endpackage

/* File: tb/iicc_axis_model.sv */
// servo axis and sensor model: counts steps and raises the general inputs
`timescale 1ns/1ps
`default_nettype none
module iicc_axis_model (
   input  wire logic        ref_clk, // clock
   input  wire logic        stepX,   // x step pulse
   input  wire logic        stepY,   // y step pulse
   input  wire logic        trigX,   // sensor 1 request
   input  wire logic        trigY,   // sensor 2 request
   output logic             genIn1,  // sensor 1 line
   output logic             genIn2,  // sensor 2 line
   output logic      [31:0] cntX,    // x steps since sensor 1 rose
   output logic      [31:0] cntY     // y steps since sensor 2 rose
);
   initial begin
      genIn1 = 1'b0;
      genIn2 = 1'b0;
      cntX = 32'h0;
      cntY = 32'h0;
   end
   // counts restart at the edge the sensor rises, so they measure travel from the trigger point
   always @(posedge ref_clk) begin
      genIn1 <= trigX;
      genIn2 <= trigY;
      cntX <= (trigX && !genIn1) ? 32'h0 : cntX + {31'h0, stepX};
      cntY <= (trigY && !genIn2) ? 32'h0 : cntY + {31'h0, stepY};
   end
endmodule
`default_nettype wire

/* File: tb/iicc_ctrl_checker.sv */
// port assertions for the inching controller
`timescale 1ns/1ps
`default_nettype none
module iicc_ctrl_checker (
   input wire logic        ref_clk,  // clock
   input wire logic        rstn,     // reset, active low
   input wire logic        wbCyc,    // cycle
   input wire logic        wbStb,    // strobe
   input wire logic        wbWe,     // write enable
   input wire logic [3:0]  wbSel,    // byte selects
   input wire logic [7:0]  wbAdr,    // address
   input wire logic [31:0] wbDatI,   // write data
   input wire logic [31:0] wbDatO,   // read data
   input wire logic        wbAck,    // acknowledge
   input wire logic        stepX,    // x step
   input wire logic        stepY,    // y step
   input wire logic [31:0] speedCmd, // speed to drive
   input wire logic        irq       // interrupt
);
   logic [31:0] vmax_r;
   logic        vmaxOk_r;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rstn);
   sequence s_take;
      wbCyc && wbStb && !wbAck;
   endsequence
   sequence s_wr(a);
      wbAck && wbWe && wbSel == 4'hf && wbAdr == a;
   endsequence
   // tracks the maximum feed rate software last wrote
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         vmaxOk_r <= 1'b0;
         vmax_r <= 32'h0;
      end else if (wbAck && wbWe && wbSel == 4'hf && wbAdr == iicc_pkg::ADR_VMAX) begin
         vmaxOk_r <= 1'b1;
         vmax_r <= wbDatI;
      end
   end
   a_ack_pulse: assert property (wbAck |=> !wbAck) else $error("ack longer than one cycle");
   a_ack_answer: assert property (s_take |=> wbAck) else $error("request not acknowledged");
   a_reset_outs: assert property (disable iff (1'b0) !rstn |=> !wbAck && !irq && speedCmd == 32'h0 && !stepX && !stepY)
      else $error("outputs not cleared by reset");
   a_one_axis: assert property (!(stepX && stepY)) else $error("both axes stepped");
   a_step_moving: assert property (stepX || stepY |-> speedCmd != 32'h0 || $past(speedCmd) != 32'h0)
      else $error("step without speed");
   a_speed_cap: assert property (vmaxOk_r && speedCmd != 32'h0 |-> speedCmd <= vmax_r)
      else $error("speed above maximum");
   a_rdata_hold: assert property (!(wbCyc && wbStb && !wbWe && !wbAck) |=> $stable(wbDatO))
      else $error("read data changed without read");
   a_irq_mask: assert property (s_wr(iicc_pkg::ADR_IRQEN) ##0 wbDatI == 32'h0 |-> ##[1:2] !irq)
      else $error("interrupt high while all masked");
endmodule
bind iicc_ctrl iicc_ctrl_checker iicc_ctrl_checker_inst (.ref_clk(ref_clk), .rstn(rstn), .wbCyc(wbCyc),
   .wbStb(wbStb), .wbWe(wbWe), .wbSel(wbSel), .wbAdr(wbAdr), .wbDatI(wbDatI), .wbDatO(wbDatO),
   .wbAck(wbAck), .stepX(stepX), .stepY(stepY), .speedCmd(speedCmd), .irq(irq));
`default_nettype wire

/* File: tb/tb.sv */
// testbench for the inching and coordinate frame controller
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic        ref_clk = 1'b0;
   logic        rstn = 1'b0;
   logic        wbCyc = 1'b0;
   logic        wbStb = 1'b0;
   logic        wbWe = 1'b0;
   logic [3:0]  wbSel = 4'h0;
   logic [7:0]  wbAdr = 8'h00;
   logic [31:0] wbDatI = 32'h0;
   logic        trigX = 1'b0;
   logic        trigY = 1'b0;
   logic [31:0] wbDatO, speedCmd, cntX, cntY;
   logic [15:0] rampTime;
   logic        wbAck, genIn1, genIn2, stepX, stepY, dirOut, irq;
   int          fail_count = 0;
   int          tests_run = 0;
   always #20 ref_clk = ~ref_clk;
   iicc_ctrl iicc_ctrl_inst (.ref_clk(ref_clk), .rstn(rstn), .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe),
      .wbSel(wbSel), .wbAdr(wbAdr), .wbDatI(wbDatI), .wbDatO(wbDatO), .wbAck(wbAck), .genIn1(genIn1),
      .genIn2(genIn2), .stepX(stepX), .stepY(stepY), .dirOut(dirOut), .speedCmd(speedCmd),
      .rampTime(rampTime), .irq(irq));
   iicc_axis_model iicc_axis_model_inst (.ref_clk(ref_clk), .stepX(stepX), .stepY(stepY), .trigX(trigX),
      .trigY(trigY), .genIn1(genIn1), .genIn2(genIn2), .cntX(cntX), .cntY(cntY));
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
      tests_run++;
      if (s !== e) begin
         fail_count++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
      int n;
      n = 0;
      @(posedge ref_clk);
      wbCyc <= 1'b1;
      wbStb <= 1'b1;
      wbWe <= we;
      wbSel <= 4'hf;
      wbAdr <= a;
      wbDatI <= d;
      do begin
         @(posedge ref_clk);
         n++;
      end while (wbAck !== 1'b1 && n < 20);
      q = wbDatO;
      wbCyc <= 1'b0;
      wbStb <= 1'b0;
      wbWe <= 1'b0;
      if (n >= 20) chk("bus answer", 32'h1, 32'h0);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask
   task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      logic [31:0] q;
      bus(1'b0, a, 32'h0, q);
      chk(nm, e, q & m);
   endtask
   task automatic wait_irq(input int b);
      logic [31:0] q;
      int n;
      n = 0;
      do begin
         bus(1'b0, iicc_pkg::ADR_IRQST, 32'h0, q);
         n++;
      end while (q[b] !== 1'b1 && n < 400);
      chk("status bit", 32'h1, {31'h0, q[b]});
   endtask
   // raise a sensor just after a step so the count from the trigger point is exact
   task automatic fire(input logic y);
      int n;
      n = 0;
      do begin
         @(posedge ref_clk);
         n++;
      end while ((y ? stepY : stepX) !== 1'b1 && n < 200);
      if (y) trigY <= 1'b1;
      else trigX <= 1'b1;
      repeat (10) @(posedge ref_clk);
      trigX <= 1'b0;
      trigY <= 1'b0;
   endtask
   task automatic t_regs();
      wr(iicc_pkg::ADR_IRQEN, 32'h0);
      rd("override", iicc_pkg::ADR_OVR, 32'hffffffff, iicc_pkg::OVR_FULL);
      rd("unmapped", 8'hfc, 32'hffffffff, 32'h0);
      rd("irq status", iicc_pkg::ADR_IRQST, 32'h1f, 32'h0);
      rd("frame", iicc_pkg::ADR_FRAME, 32'h1, 32'h0);
   endtask
   task automatic t_inch_x();
      wr(iicc_pkg::ADR_VMAX, 32'h001e8480);
      wr(iicc_pkg::ADR_SPD1, 32'h000f4240);
      wr(iicc_pkg::ADR_DIST, 32'h4);
      wr(iicc_pkg::ADR_IRQEN, 32'h1);
      wr(iicc_pkg::ADR_RAMP, 32'h64);
      wr(iicc_pkg::ADR_CTRL, {28'h0, iicc_pkg::CMD_INCH});
      repeat (300) @(posedge ref_clk);
      chk("feed before trigger", 32'h1, {31'h0, cntX != 32'h0});
      chk("ramp scaled", 32'h32, {16'h0, rampTime});
      rd("stop mode", iicc_pkg::ADR_STAT, 32'h8, 32'h8);
      fire(1'b0);
      wait_irq(iicc_pkg::IRQ_DONE);
      chk("x steps", 32'h4, cntX);
      chk("y steps", 32'h0, cntY);
      rd("x position", iicc_pkg::ADR_POSX, 32'hffffffff, 32'h4);
      chk("irq", 32'h1, {31'h0, irq});
      wr(iicc_pkg::ADR_IRQCLR, 32'h1f);
      repeat (2) @(posedge ref_clk);
      chk("irq cleared", 32'h0, {31'h0, irq});
   endtask
   task automatic t_inch_y();
      wr(iicc_pkg::ADR_OVR, 32'h1f4);
      wr(iicc_pkg::ADR_SPD1, 32'h002dc6c0);
      wr(iicc_pkg::ADR_SLIM, 32'h3e8);
      wr(iicc_pkg::ADR_CTRL, {28'h0, iicc_pkg::CMD_INCH} | 32'h250);
      repeat (100) @(posedge ref_clk);
      chk("capped speed", 32'h001e8480, speedCmd);
      chk("capped ramp", 32'h64, {16'h0, rampTime});
      chk("direction", 32'h1, {31'h0, dirOut});
      fire(1'b0);
      repeat (200) @(posedge ref_clk);
      rd("no early done", iicc_pkg::ADR_IRQST, 32'h1, 32'h0);
      fire(1'b1);
      wait_irq(iicc_pkg::IRQ_DONE);
      chk("y steps", 32'h4, cntY);
      chk("x steps", 32'h0, cntX);
      wr(iicc_pkg::ADR_IRQCLR, 32'h1f);
   endtask
   task automatic t_speed2();
      wr(iicc_pkg::ADR_OVR, iicc_pkg::OVR_FULL);
      wr(iicc_pkg::ADR_SPD1, 32'h000f4240);
      wr(iicc_pkg::ADR_SPD2, 32'h000f4240);
      wr(iicc_pkg::ADR_CTRL, {28'h0, iicc_pkg::CMD_INCH} | 32'h20);
      wait_irq(iicc_pkg::IRQ_SPDERR);
      repeat (50) @(posedge ref_clk);
      chk("refused speed", 32'h0, speedCmd);
      chk("refused steps", 32'h0, cntX);
      wr(iicc_pkg::ADR_CTRL, {28'h0, iicc_pkg::CMD_INCH});
      repeat (60) @(posedge ref_clk);
      wr(iicc_pkg::ADR_CTRL, {28'h0, iicc_pkg::CMD_STOP});
      wait_irq(iicc_pkg::IRQ_DONE);
      chk("stopped speed", 32'h0, speedCmd);
      wr(iicc_pkg::ADR_IRQCLR, 32'h1f);
      wr(iicc_pkg::ADR_SPD2, 32'h0007a120);
      wr(iicc_pkg::ADR_CTRL, {28'h0, iicc_pkg::CMD_INCH} | 32'h20);
      fire(1'b0);
      chk("slow speed", 32'h0007a120, speedCmd);
      wait_irq(iicc_pkg::IRQ_DONE);
      chk("slow steps", 32'h4, cntX);
   endtask
   task automatic t_frames();
      logic [3:0] cmd [6] = '{iicc_pkg::CMD_WRKSEL, iicc_pkg::CMD_REFSEL, iicc_pkg::CMD_WRKRET,
                              iicc_pkg::CMD_OSRCH, iicc_pkg::CMD_WRKSEL, iicc_pkg::CMD_REFRET};
      for (int i = 0; i < 6; i++) begin
         wr(iicc_pkg::ADR_CTRL, {28'h0, cmd[i]});
         rd("frame", iicc_pkg::ADR_FRAME, 32'h1, {31'h0, ~i[0]});
      end
      wr(iicc_pkg::ADR_SLIM, 32'h3e8);
      wr(iicc_pkg::ADR_POFS, 32'h7);
      wr(iicc_pkg::ADR_CTRL, {28'h0, iicc_pkg::CMD_PSTART});
      rd("start offset", iicc_pkg::ADR_WOFS, 32'hffffffff, 32'h7);
      wr(iicc_pkg::ADR_CTRL, {28'h0, iicc_pkg::CMD_INTERP});
      rd("pass mode", iicc_pkg::ADR_STAT, 32'h8, 32'h0);
      wr(iicc_pkg::ADR_OFS, 32'h7d0);
      wr(iicc_pkg::ADR_CTRL, {28'h0, iicc_pkg::CMD_SETOFS});
      wait_irq(iicc_pkg::IRQ_OFSERR);
      wr(iicc_pkg::ADR_OFS, 32'h64);
      wr(iicc_pkg::ADR_CTRL, {28'h0, iicc_pkg::CMD_SETOFS});
      rd("working offset", iicc_pkg::ADR_WOFS, 32'hffffffff, 32'h64);
      rd("stored offset", iicc_pkg::ADR_POFS, 32'hffffffff, 32'h7);
   endtask
   initial begin
      repeat (5) @(posedge ref_clk);
      rstn <= 1'b1;
      t_regs();
      t_inch_x();
      t_inch_y();
      t_speed2();
      t_frames();
      give_verdict();
   end
   initial begin
      repeat (30000) @(posedge ref_clk);
      fail_count++;
      give_verdict();
   end
endmodule
`default_nettype wire
